/* File: tb_tihc_core.sv */
module tb_tihc_core;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst_b, carryIn, regWrite, regRead, irqPinN, extClk;
	logic timerJumpTaken, sysClockEnable, lcdBlank, initDefaults;
	logic [11:0] returnPc, wakePinsN;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata;
	tihc_pkg::tihc_instr_type instr;
	tihc_pkg::tihc_flow_type flow, f;
	tihc_pkg::tihc_phase_type phase;
	int num_errors, n_compared;
	logic aux;
	logic [7:0] divRdata, extRdata;
	tihc_pkg::tihc_instr_type instrAux;
	tihc_core dut_u (.ref_clk, .rst_b, .instr, .returnPc, .carryIn,
		.irqPinN, .extTimerClockPin(extClk), .inputPortOne(wakePinsN[3:0]),
		.inputPortTwo(wakePinsN[7:4]), .inputPortThree(wakePinsN[11:8]),
		.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .flow,
		.timerJumpTaken, .phase, .sysClockEnable, .lcdBlank, .initDefaults);
	tihc_core #(.TIMER_DIV_N(2)) dut_div_u (.ref_clk, .rst_b,
		.instr(instrAux), .returnPc, .carryIn, .irqPinN,
		.extTimerClockPin(extClk), .inputPortOne(wakePinsN[3:0]),
		.inputPortTwo(wakePinsN[7:4]), .inputPortThree(wakePinsN[11:8]),
		.regAddr, .regWdata, .regWrite, .regRead, .regRdata(divRdata),
		.flow(), .timerJumpTaken(), .phase(), .sysClockEnable(),
		.lcdBlank(), .initDefaults());
	tihc_core #(.EXT_TIMER_CLOCK(1'b1)) dut_ext_u (.ref_clk, .rst_b,
		.instr(instrAux), .returnPc, .carryIn, .irqPinN,
		.extTimerClockPin(extClk), .inputPortOne(wakePinsN[3:0]),
		.inputPortTwo(wakePinsN[7:4]), .inputPortThree(wakePinsN[11:8]),
		.regAddr, .regWdata, .regWrite, .regRead, .regRdata(extRdata),
		.flow(), .timerJumpTaken(), .phase(), .sysClockEnable(),
		.lcdBlank(), .initDefaults());
	tihc_pins pins_u (.ref_clk, .irqPinN, .extTimerClockPin(extClk),
		.wakePinsN);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	// 0 on, 1 off, 2 load, 3 enable, 4 disable, 5 call, 6 ret, 7 irq_return_instr,
	// 8 jump on flag, other halt
	task automatic op(input int k, input logic [7:0] v);
		tihc_pkg::tihc_instr_type i;
		i = '0;
		case (k)
			0: i.timerOn = 1'b1;
			1: i.timerOff = 1'b1;
			2: begin
				i.timerLoad = 1'b1;
				i.loadValue = v;
			end
			3: i.irqEnableInstr = 1'b1;
			4: i.irqDisableInstr = 1'b1;
			5: begin
				i.call = 1'b1;
				i.callTarget = 12'h200;
			end
			6: i.subReturnInstr = 1'b1;
			7: i.irqReturnInstr = 1'b1;
			8: i.jumpOnTimerFlag = 1'b1;
			default: i.halt = 1'b1;
		endcase
		@(posedge ref_clk);
		instr <= i;
		instrAux <= aux ? i : '0;
		@(posedge ref_clk);
		instr <= '0;
		instrAux <= '0;
	endtask : op
	// ends one edge past the pulse so a back-to-back load is not seen twice
	task automatic nextLoad();
		int n;
		n = 0;
		#1;
		while (flow.pcLoad !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		f = flow;
		chk(n < 60, 1'b1);
		@(posedge ref_clk);
	endtask : nextLoad
	task automatic waitWake();
		int n;
		n = 0;
		// let the halt strobe land before the clock enable is looked at
		#1;
		while (sysClockEnable !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(sysClockEnable, 1'b1);
	endtask : waitWake
	task automatic t_reset();
		logic [7:0] d;
		rd(tihc_pkg::REG_STATUS, d);
		chk(d, 8'h00);
		rd(tihc_pkg::REG_COUNT, d);
		chk(d, 8'h00);
		rd(4'hF, d);
		chk(d, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_timer();
		logic [7:0] a, b;
		op(2, 8'hFF);
		op(0, 8'h00);
		repeat (3) @(posedge ref_clk);
		rd(tihc_pkg::REG_STATUS, a);
		chk(a, 8'h03);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= tihc_pkg::REG_COUNT;
		@(posedge ref_clk);
		#1 a = regRdata;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 b = regRdata;
		chk(b, a + 8'h01);
		op(1, 8'h00);
		rd(tihc_pkg::REG_COUNT, a);
		repeat (5) @(posedge ref_clk);
		rd(tihc_pkg::REG_COUNT, b);
		chk(b, a);
		op(8, 8'h00);
		#1 chk(timerJumpTaken, 1'b1);
		op(8, 8'h00);
		#1 chk(timerJumpTaken, 1'b0);
		op(2, 8'hFF);
		op(0, 8'h00);
		op(3, 8'h00);
		nextLoad();
		chk(f.pcValue, tihc_pkg::VEC_TIMER);
		op(1, 8'h00);
		rd(tihc_pkg::REG_STATUS, a);
		chk(a[tihc_pkg::ST_FLAG], 1'b0);
		op(7, 8'h00);
		nextLoad();
		$display("timer test done");
	endtask : t_timer
	task automatic t_prio();
		logic [7:0] s;
		carryIn <= 1'b1;
		op(5, 8'h00);
		nextLoad();
		op(2, 8'hFF);
		op(0, 8'h00);
		pins_u.fall(0);
		op(1, 8'h00);
		rd(tihc_pkg::REG_STATUS, s);
		chk(s, 8'h4E);
		op(6, 8'h00);
		nextLoad();
		chk(f.pcValue, 12'h123);
		nextLoad();
		chk(f.pcValue, tihc_pkg::VEC_EXT);
		carryIn <= 1'b0;
		op(7, 8'h00);
		nextLoad();
		chk({f.carryLoad, f.carryValue}, 2'b11);
		nextLoad();
		chk(f.pcValue, tihc_pkg::VEC_TIMER);
		op(7, 8'h00);
		nextLoad();
		$display("priority test done");
	endtask : t_prio
	task automatic t_halt();
		op(4, 8'h00);
		op(9, 8'h00);
		#1 chk({sysClockEnable, lcdBlank}, 2'b01);
		repeat (10) @(posedge ref_clk);
		#1 chk(sysClockEnable, 1'b0);
		fork
			pins_u.fall(0);
		join_none
		waitWake();
		repeat (8) begin
			@(posedge ref_clk);
			#1 chk(flow.pcLoad, 1'b0);
		end
		op(3, 8'h00);
		nextLoad();
		chk(f.pcValue, tihc_pkg::VEC_EXT);
		op(7, 8'h00);
		nextLoad();
		wr(tihc_pkg::REG_WAKEMASK_LO, 8'h01);
		wr(tihc_pkg::REG_WAKEMASK_HI, 8'h00);
		op(9, 8'h00);
		fork
			pins_u.fall(1);
		join_none
		waitWake();
		nextLoad();
		chk(f.pcValue, tihc_pkg::VEC_EXT);
		$display("halt test done");
	endtask : t_halt
	// 40 running edges: every clock at n=0, every fourth at n=2
	task automatic t_div();
		logic [7:0] d;
		aux = 1'b1;
		op(2, 8'h00);
		op(0, 8'h00);
		repeat (38) @(posedge ref_clk);
		op(1, 8'h00);
		rd(tihc_pkg::REG_COUNT, d);
		chk(d, 8'h28);
		chk(divRdata, 8'h0A);
		$display("divider test done");
	endtask : t_div
	task automatic t_ext();
		logic [7:0] d;
		op(2, 8'hFE);
		op(0, 8'h00);
		pins_u.pulseClk(3);
		op(1, 8'h00);
		rd(tihc_pkg::REG_COUNT, d);
		chk(extRdata, 8'h01);
		rd(tihc_pkg::REG_STATUS, d);
		chk(extRdata[tihc_pkg::ST_FLAG], 1'b1);
		$display("external clock test done");
	endtask : t_ext
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		rst_b = 1'b0;
		instr = '0;
		instrAux = '0;
		aux = 1'b0;
		returnPc = 12'h123;
		carryIn = 1'b0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		num_errors = 0;
		n_compared = 0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_timer();
		t_prio();
		t_halt();
		t_div();
		t_ext();
		results();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		results();
	end
endmodule : tb_tihc_core

/* File: tihc_core.sv */
// Operation
// [RULE1] 8-bit counter increments on selected clock edge
// [RULE2] reset or timer-off stops the counter
// [RULE3] load start value then timer-on counts up
// [RULE4] wraps FFH to 00H and keeps counting
// [RULE5] wrap sets overflow flag and internal request
// [RULE6] flag tested by jump, cleared by jump/service
// [RULE7] internal clock is system clock over 2^n
// [RULE8] stop timer before reading external-clock count
// [RULE9] interrupts off at reset/disable until enable
// [RULE10] falling interrupt edge calls address 8
// [RULE11] overflow flag calls address 4 when allowed
// [RULE12] simultaneous requests: external one first
// [RULE13] requests held during call or disable
// [RULE14] no call inside an interrupt routine
// [RULE15] external reset held low at least 5ms
// [RULE16] reset: pc zero, irq off, timer cleared
// [RULE17] halt stops clock, keeps state, blanks display
// [RULE18] only reset or external edge ends halt
// [RULE19] disabled halt wake resumes, request stays pending
// [RULE20] enabled halt wake runs external service
// [RULE21] machine cycle is four states T1..T4
// [RULE22] interrupt stacks pc and carry; return restores
// [RULE23] pin inputs pass two flip-flops first
module tihc_core #(
	parameter bit EXT_TIMER_CLOCK = 1'b0,
	parameter int TIMER_DIV_N = 0,
	parameter logic [tihc_pkg::WAKE_WIDTH-1:0] WAKE_MASK_DEF =
		tihc_pkg::WAKE_MASK_RESET
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire tihc_pkg::tihc_instr_type instr,
	input wire logic [tihc_pkg::PC_WIDTH-1:0] returnPc,
	input wire logic carryIn,
	input wire logic irqPinN,
	input wire logic extTimerClockPin,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortOne,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortTwo,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortThree,
	input wire logic [tihc_pkg::ADDR_WIDTH-1:0] regAddr,
	input wire logic [tihc_pkg::DATA_WIDTH-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [tihc_pkg::DATA_WIDTH-1:0] regRdata,
	output tihc_pkg::tihc_flow_type flow,
	output logic timerJumpTaken,
	output tihc_pkg::tihc_phase_type phase,
	output logic sysClockEnable,
	output logic lcdBlank,
	output logic initDefaults
);
	localparam int PW = tihc_pkg::PRESCALE_WIDTH;
	localparam int TW = tihc_pkg::TIMER_WIDTH;
	localparam int WW = tihc_pkg::WAKE_WIDTH;
	localparam int DW = tihc_pkg::DATA_WIDTH;
	// a reserved or out-of-range divider falls back to the undivided clock
	localparam bit DIV_OK = TIMER_DIV_N >= 0 &&
		TIMER_DIV_N <= tihc_pkg::DIV_N_MAX &&
		TIMER_DIV_N != tihc_pkg::DIV_N_RESERVED; // RULE7
	localparam int DIV_N = DIV_OK ? TIMER_DIV_N : 0;
	localparam logic [PW-1:0] PRE_MASK =
		PW'((64'd1 << DIV_N) - 64'd1); // RULE7

	function automatic logic fell(input logic prevV, input logic nowV);
		return prevV & ~nowV;
	endfunction : fell

	// synchronisers for every pin-side input
	logic [1:0] irqSync_reg;
	logic [1:0] tclkSync_reg;
	logic [WW-1:0] wakeMeta_reg;
	logic [WW-1:0] wakeSync_reg;
	logic irqPrev_reg;
	logic tclkPrev_reg;
	logic [WW-1:0] wakePrev_reg;
	logic [WW-1:0] wakeRaw;

	assign wakeRaw = {inputPortThree, inputPortTwo, inputPortOne};

	// the asynchronous wake path is not modelled: ref_clk keeps running
	// and only the core clock enable stops, so halt still sees edges
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqSync_reg <= 2'b11;
			tclkSync_reg <= 2'b00;
			wakeMeta_reg <= '1;
			wakeSync_reg <= '1;
			irqPrev_reg <= 1'b1;
			tclkPrev_reg <= 1'b0;
			wakePrev_reg <= '1;
		end else begin
			irqSync_reg <= {irqSync_reg[0], irqPinN}; // RULE23
			tclkSync_reg <= {tclkSync_reg[0], extTimerClockPin}; // RULE23
			wakeMeta_reg <= wakeRaw;
			wakeSync_reg <= wakeMeta_reg; // RULE23
			irqPrev_reg <= irqSync_reg[1];
			tclkPrev_reg <= tclkSync_reg[1];
			wakePrev_reg <= wakeSync_reg;
		end
	end

	logic irqEdge;
	logic tclkRise;
	logic [WW-1:0] wakeMask_reg;
	logic wakeEdge;

	assign irqEdge = fell(irqPrev_reg, irqSync_reg[1]);
	assign tclkRise = fell(tclkSync_reg[1], tclkPrev_reg);
	assign wakeEdge = |(wakePrev_reg & ~wakeSync_reg & wakeMask_reg);

	// halt and machine-cycle sequencing
	logic halted_reg;
	logic wakeNow;

	assign wakeNow = halted_reg & (irqEdge | wakeEdge); // RULE18

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			halted_reg <= 1'b0;
		end else if (wakeNow) begin
			halted_reg <= 1'b0; // RULE19
		end else if (instr.halt) begin
			halted_reg <= 1'b1; // RULE17
		end
	end

	assign sysClockEnable = ~halted_reg; // RULE17
	assign lcdBlank = halted_reg; // RULE17

	tihc_pkg::tihc_phase_type phase_reg;
	tihc_pkg::tihc_phase_type phase_next;

	always_comb begin
		unique case (phase_reg)
			tihc_pkg::PH_T1: phase_next = tihc_pkg::PH_T2;
			tihc_pkg::PH_T2: phase_next = tihc_pkg::PH_T3;
			tihc_pkg::PH_T3: phase_next = tihc_pkg::PH_T4;
			tihc_pkg::PH_T4: phase_next = tihc_pkg::PH_T1;
			default: phase_next = tihc_pkg::PH_T1;
		endcase
	end

	// the state sequence freezes while halted, as the oscillator would
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= tihc_pkg::PH_T1;
		end else if (!halted_reg) begin
			phase_reg <= phase_next; // RULE21
		end
	end

	assign phase = phase_reg;

	// timer clock selection
	logic [PW-1:0] prescale_reg;
	logic tick;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_reg <= '0;
		end else if (!halted_reg) begin
			prescale_reg <= prescale_reg + PW'(1); // RULE7
		end
	end

	// the external source keeps counting in halt: it needs no system clock
	assign tick = EXT_TIMER_CLOCK ? tclkRise :
		(~halted_reg & ((prescale_reg & PRE_MASK) == PRE_MASK)); // RULE1

	// timer counter
	logic running_reg;
	logic [TW-1:0] count_reg;
	logic overflow;
	logic cpuCountWrite;

	assign cpuCountWrite = regWrite & (regAddr == tihc_pkg::REG_COUNT);
	assign overflow = running_reg & tick &
		(count_reg == tihc_pkg::TIMER_MAX); // RULE5

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			running_reg <= 1'b0; // RULE16
		end else if (instr.timerOff) begin
			running_reg <= 1'b0; // RULE2
		end else if (instr.timerOn) begin
			running_reg <= 1'b1; // RULE3
		end
	end

	// a read of an externally clocked count can tear; software stops first
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= tihc_pkg::TIMER_RESET; // RULE16
		end else if (instr.timerLoad) begin
			count_reg <= instr.loadValue; // RULE3
		end else if (cpuCountWrite) begin
			count_reg <= regWdata[TW-1:0]; // RULE8
		end else if (running_reg && tick) begin
			count_reg <= count_reg + TW'(1); // RULE1 RULE4
		end
	end

	// interrupt control
	logic irqEnabled_reg;
	logic inCall_reg;
	logic inIrq_reg;
	logic flag_reg;
	logic extPend_reg;
	logic extFromWake_reg;
	logic svcSlot;
	logic takeExt;
	logic takeTimer;
	logic takeAny;
	logic jumpClear;

	// a wake edge waits like any request; all requests sample at T4 once halt has ended
	assign svcSlot = ~halted_reg & (phase_reg == tihc_pkg::PH_T4);
	assign takeExt = svcSlot & irqEnabled_reg & ~inCall_reg &
		extPend_reg; // RULE10 RULE12 RULE13
	assign takeTimer = svcSlot & irqEnabled_reg & ~inCall_reg &
		~extPend_reg & flag_reg; // RULE11 RULE12 RULE13
	assign takeAny = takeExt | takeTimer;
	assign jumpClear = instr.jumpOnTimerFlag;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqEnabled_reg <= 1'b0; // RULE16
		end else if (instr.irqDisableInstr) begin
			irqEnabled_reg <= 1'b0; // RULE9
		end else if (instr.irqEnableInstr) begin
			irqEnabled_reg <= 1'b1; // RULE9
		end
	end

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_reg <= 1'b0; // RULE16
		end else if (overflow) begin
			flag_reg <= 1'b1; // RULE5
		end else if (takeTimer || jumpClear) begin
			flag_reg <= 1'b0; // RULE6 RULE11
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			extPend_reg <= 1'b0;
		end else if (irqEdge || wakeNow) begin
			extPend_reg <= 1'b1; // RULE10 RULE19
		end else if (takeExt) begin
			extPend_reg <= 1'b0; // RULE10
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			extFromWake_reg <= 1'b0;
		end else if (wakeNow) begin
			extFromWake_reg <= ~irqEdge;
		end else if (irqEdge || takeExt) begin
			extFromWake_reg <= 1'b0;
		end
	end

	// calling from inside a service routine overwrites the single stack
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			inCall_reg <= 1'b0;
			inIrq_reg <= 1'b0;
		end else if (takeAny) begin
			inCall_reg <= 1'b1; // RULE13
			inIrq_reg <= 1'b1;
		end else if (instr.call) begin
			inCall_reg <= 1'b1; // RULE13 RULE14
		end else if (instr.subReturnInstr || instr.irqReturnInstr) begin
			inCall_reg <= 1'b0; // RULE13
			inIrq_reg <= 1'b0;
		end
	end

	// single-level stack of pc plus carry
	logic [tihc_pkg::PC_WIDTH-1:0] stackPc_reg;
	logic stackCarry_reg;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stackPc_reg <= tihc_pkg::VEC_RESET;
			stackCarry_reg <= 1'b0;
		end else if (takeAny) begin
			stackPc_reg <= returnPc; // RULE22
			stackCarry_reg <= carryIn; // RULE22
		end else if (instr.call) begin
			stackPc_reg <= returnPc;
		end
	end

	// program flow answers, one cycle after the cause
	logic startup_reg;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			startup_reg <= 1'b1;
		end else begin
			startup_reg <= 1'b0;
		end
	end

	assign initDefaults = startup_reg; // RULE16

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flow <= '0;
		end else begin
			flow.pcLoad <= 1'b0;
			flow.carryLoad <= 1'b0;
			if (startup_reg) begin
				flow.pcLoad <= 1'b1; // RULE16
				flow.pcValue <= tihc_pkg::VEC_RESET; // RULE16
				flow.carryLoad <= 1'b1; // RULE16
				flow.carryValue <= 1'b0; // RULE16
			end else if (takeExt) begin
				flow.pcLoad <= 1'b1;
				flow.pcValue <= tihc_pkg::VEC_EXT; // RULE10 RULE20
			end else if (takeTimer) begin
				flow.pcLoad <= 1'b1;
				flow.pcValue <= tihc_pkg::VEC_TIMER; // RULE11
			end else if (instr.call) begin
				flow.pcLoad <= 1'b1;
				flow.pcValue <= instr.callTarget;
			end else if (instr.irqReturnInstr) begin
				flow.pcLoad <= 1'b1;
				flow.pcValue <= stackPc_reg; // RULE22
				flow.carryLoad <= 1'b1;
				flow.carryValue <= stackCarry_reg; // RULE22
			end else if (instr.subReturnInstr) begin
				flow.pcLoad <= 1'b1;
				flow.pcValue <= stackPc_reg; // RULE22
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			timerJumpTaken <= 1'b0;
		end else begin
			timerJumpTaken <= jumpClear & flag_reg; // RULE6
		end
	end

	// register port
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wakeMask_reg <= tihc_pkg::WAKE_MASK_RESET;
		end else if (startup_reg) begin
			wakeMask_reg <= WAKE_MASK_DEF;
		end else if (regWrite && regAddr == tihc_pkg::REG_WAKEMASK_LO) begin
			wakeMask_reg[DW-1:0] <= regWdata;
		end else if (regWrite && regAddr == tihc_pkg::REG_WAKEMASK_HI) begin
			wakeMask_reg[WW-1:DW] <= regWdata[WW-DW-1:0];
		end
	end

	logic [DW-1:0] status;

	always_comb begin
		status = '0;
		status[tihc_pkg::ST_RUN] = running_reg;
		status[tihc_pkg::ST_FLAG] = flag_reg;
		status[tihc_pkg::ST_IRQEN] = irqEnabled_reg;
		status[tihc_pkg::ST_INCALL] = inCall_reg;
		status[tihc_pkg::ST_INIRQ] = inIrq_reg;
		status[tihc_pkg::ST_HALT] = halted_reg;
		status[tihc_pkg::ST_EXTPEND] = extPend_reg;
		status[tihc_pkg::ST_EXTSRC] = extFromWake_reg;
	end

	// unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdata <= '0;
		end else if (regRead) begin
			unique case (regAddr)
				tihc_pkg::REG_COUNT: regRdata <= count_reg;
				tihc_pkg::REG_STATUS: regRdata <= status;
				tihc_pkg::REG_WAKEMASK_LO: regRdata <= wakeMask_reg[DW-1:0];
				tihc_pkg::REG_WAKEMASK_HI:
					regRdata <= {4'h0, wakeMask_reg[WW-1:DW]};
				default: regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end
endmodule : tihc_core

/* File: tihc_core_sva.sv */
module tihc_core_sva (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire tihc_pkg::tihc_instr_type instr,
	input wire logic irqPinN,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortOne,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortTwo,
	input wire logic [tihc_pkg::PORT_WIDTH-1:0] inputPortThree,
	input wire tihc_pkg::tihc_flow_type flow,
	input wire logic timerJumpTaken,
	input wire tihc_pkg::tihc_phase_type phase,
	input wire logic sysClockEnable,
	input wire logic lcdBlank,
	input wire logic initDefaults
);
	timeunit 1ns;
	timeprecision 1ns;
	logic quiet;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// four quiet samples rule out a wake edge still in the synchroniser
	assign quiet = irqPinN && (&{inputPortOne, inputPortTwo, inputPortThree});
	rst_vec_a: assert property (initDefaults |=> flow.pcLoad
		&& flow.pcValue == tihc_pkg::VEC_RESET && flow.carryLoad
		&& !flow.carryValue) else $error("reset vector wrong");
	halt_stop_a: assert property (instr.halt && sysClockEnable
		|=> !sysClockEnable) else $error("halt kept clock");
	lcd_blank_a: assert property (lcdBlank == !sysClockEnable)
		else $error("blank mismatch");
	phase_hot_a: assert property ($onehot(phase))
		else $error("phase not one-hot");
	phase_step_a: assert property (phase == tihc_pkg::PH_T4
		&& sysClockEnable |=> phase == tihc_pkg::PH_T1)
		else $error("phase did not wrap");
	jump_src_a: assert property (timerJumpTaken
		|-> $past(instr.jumpOnTimerFlag)) else $error("spurious jump");
	halt_hold_a: assert property ((!sysClockEnable && quiet)[*4]
		|=> !sysClockEnable) else $error("halt ended alone");
	irq_return_instr_carry_a: assert property (instr.irqReturnInstr
		|=> flow.pcLoad && flow.carryLoad) else $error("irq_return_instr lost carry");
	ret_carry_a: assert property (instr.subReturnInstr
		|=> flow.pcLoad && !flow.carryLoad) else $error("ret set carry");
	cover property (flow.pcLoad && flow.pcValue == tihc_pkg::VEC_EXT);
	cover property (flow.pcLoad && flow.pcValue == tihc_pkg::VEC_TIMER);
	cover property ($rose(sysClockEnable));
endmodule : tihc_core_sva

bind tihc_core tihc_core_sva chk_u (
	.ref_clk, .rst_b, .instr, .irqPinN, .inputPortOne, .inputPortTwo,
	.inputPortThree, .flow, .timerJumpTaken, .phase, .sysClockEnable,
	.lcdBlank, .initDefaults
);

/* File: tihc_pins.sv */
module tihc_pins (
	input wire logic ref_clk,
	output logic irqPinN,
	output logic extTimerClockPin,
	output logic [11:0] wakePinsN
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-ups hold idle pins high; the timer pin stands still
	initial begin
		irqPinN = 1'b1;
		extTimerClockPin = 1'b0;
		wakePinsN = 12'hFFF;
	end
	// k 0 is the interrupt pin, k 1..12 a wake bit; low long enough to sync
	task automatic fall(input int k);
		@(posedge ref_clk);
		if (k == 0) irqPinN <= 1'b0;
		else wakePinsN[k-1] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		irqPinN <= 1'b1;
		wakePinsN <= 12'hFFF;
	endtask : fall
	// each level stands three samples so the synchroniser sees every rise
	task automatic pulseClk(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			extTimerClockPin <= 1'b1;
			repeat (3) @(posedge ref_clk);
			extTimerClockPin <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask : pulseClk
endmodule : tihc_pins

/* File: tihc_pkg.sv */
package tihc_pkg;
	localparam int TIMER_WIDTH = 8;
	localparam int PC_WIDTH = 12;
	localparam int PORT_WIDTH = 4;
	localparam int WAKE_WIDTH = 12;
	localparam int ADDR_WIDTH = 4;
	localparam int DATA_WIDTH = 8;
	localparam int PRESCALE_WIDTH = 14;
	localparam int DIV_N_MAX = 13;
	localparam int DIV_N_RESERVED = 6;
	localparam logic [TIMER_WIDTH-1:0] TIMER_MAX = 8'hFF;
	localparam logic [TIMER_WIDTH-1:0] TIMER_RESET = 8'h00;
	localparam logic [PC_WIDTH-1:0] VEC_RESET = 12'h000;
	localparam logic [PC_WIDTH-1:0] VEC_TIMER = 12'h004;
	localparam logic [PC_WIDTH-1:0] VEC_EXT = 12'h008;
	localparam logic [ADDR_WIDTH-1:0] REG_COUNT = 4'h0;
	localparam logic [ADDR_WIDTH-1:0] REG_STATUS = 4'h1;
	localparam logic [ADDR_WIDTH-1:0] REG_WAKEMASK_LO = 4'h2;
	localparam logic [ADDR_WIDTH-1:0] REG_WAKEMASK_HI = 4'h3;
	localparam int ST_RUN = 0;
	localparam int ST_FLAG = 1;
	localparam int ST_IRQEN = 2;
	localparam int ST_INCALL = 3;
	localparam int ST_INIRQ = 4;
	localparam int ST_HALT = 5;
	localparam int ST_EXTPEND = 6;
	localparam int ST_EXTSRC = 7;
	localparam logic [WAKE_WIDTH-1:0] WAKE_MASK_RESET = 12'h000;

	typedef enum logic [3:0] {
		PH_T1 = 4'b0001,
		PH_T2 = 4'b0010,
		PH_T3 = 4'b0100,
		PH_T4 = 4'b1000
	} tihc_phase_type;

	typedef struct packed {
		logic timerOn;
		logic timerOff;
		logic timerLoad;
		logic [TIMER_WIDTH-1:0] loadValue;
		logic irqEnableInstr;
		logic irqDisableInstr;
		logic call;
		logic [PC_WIDTH-1:0] callTarget;
		logic subReturnInstr;
		logic irqReturnInstr;
		logic jumpOnTimerFlag;
		logic halt;
	} tihc_instr_type;

	typedef struct packed {
		logic pcLoad;
		logic [PC_WIDTH-1:0] pcValue;
		logic carryLoad;
		logic carryValue;
	} tihc_flow_type;
endpackage : tihc_pkg
